// [verilog/cmp_ctrl_regs.svh]
// Register offsets, field positions and reset values for the comparator control bank.
// Assumes a simple synchronous peripheral register port with byte offsets.
`ifndef CMP_CTRL_REGS_SVH
`define CMP_CTRL_REGS_SVH
`define OFS_IRQ_ENABLE 5'h00
`define OFS_IRQ_STATUS 5'h04
`define OFS_CONFIG_LOCK 5'h0C
`define OFS_CMP_CONTROL 5'h10
`define OFS_FILTER_CONFIG 5'h14
`define OFS_FILTER_PRESCALER 5'h18
`define CTRL_WR_MASK 16'h7B9F
`define FILC_WR_MASK 32'h000007FF
`define FILP_WR_MASK 32'h0000FFFF
`define CTRL_OUT_BIT 17
`define CTRL_POL_BIT 11
`define REG_RESET 32'h00000000
`endif

// [verilog/cmp_ctrl_pkg.sv]
// Types shared by the comparator control bank.
// Assumes the register header is compiled alongside.
package cmp_ctrl_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [31:0] wdata;
    } reg_req_s;
endpackage

// [verilog/comparator_ctrl_regs.sv]
// Software-visible control bank of the analog comparator.
// Assumes cmp_raw_i is asynchronous analog comparator output; register port is synchronous.
// Assumes the register header and the type package are compiled before this file.
// Assumes requests are single-cycle strobes that never need a wait state.
`include "cmp_ctrl_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module comparator_ctrl_regs (
    input wire logic sys_clk_i,                   // System clock, 100 MHz.
    input wire logic rst_i,                       // Synchronous active-high reset.
    input wire cmp_ctrl_pkg::reg_req_s req_i,     // Register request.
    input wire logic cmp_raw_i,                   // Raw comparator result.
    output logic [31:0] rdata_o,                  // Registered read data.
    output logic [31:0] control_o,                // Control register contents.
    output logic [31:0] filter_config_o,          // Filter configuration contents.
    output logic [31:0] filter_prescaler_o,       // Filter prescaler contents.
    output logic irq_o                            // Interrupt request.
);
    import cmp_ctrl_pkg::*;

    // The bank is a plain register file with one event source. Every access
    // completes at the edge that samples its strobe, so there is no wait state
    // and no error response. Reads return data one cycle later on rdata_o,
    // which then holds until the next read.

    // Software-visible bits of the one-bit registers.
    logic irq_permit_bit_r;
    logic irq_pending_bit_r;
    logic write_once_freeze_bit_r;
    // Remembers that the single lock write since reset has been spent.
    logic lock_used_r;
    // Synchroniser stages for the asynchronous comparator level.
    logic [2:0] sync_r;
    // Polarity-adjusted comparator result and its value one cycle earlier.
    logic out_r;
    logic out_prev_r;
    logic sync_agree;
    logic out_rise;
    logic [31:0] rdata_nxt;

    // Address match used by the write strobes; the read multiplexer decodes with its own case.
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction

    // Widens a one-bit register to a bus word with its reserved bits at 0.
    function automatic logic [31:0] one_bit_word(input logic b);
        one_bit_word = {31'h0, b};
    endfunction

    wire wr_en = req_i.wr && hit(req_i.addr, `OFS_IRQ_ENABLE);
    wire wr_st = req_i.wr && hit(req_i.addr, `OFS_IRQ_STATUS);
    wire wr_lk = req_i.wr && hit(req_i.addr, `OFS_CONFIG_LOCK);
    wire frozen = write_once_freeze_bit_r;

    // Writes to the three configuration registers are gated by the lock here,
    // once, so that every register process below sees the same decision.
    wire wr_ctrl = req_i.wr && !frozen && hit(req_i.addr, `OFS_CMP_CONTROL);
    wire wr_filc = req_i.wr && !frozen && hit(req_i.addr, `OFS_FILTER_CONFIG);
    wire wr_filp = req_i.wr && !frozen && hit(req_i.addr, `OFS_FILTER_PRESCALER);

    // The last two synchroniser stages must agree before the result moves,
    // which adds no latency to a clean change but keeps a level that is still
    // settling away from the pending logic.
    assign sync_agree = (sync_r[1] == sync_r[2]);

    // The pending bit reacts to the moment the adjusted result becomes 1,
    // not to its level, so a result that stays high does not re-arm it
    // after software has cleared it.
    assign out_rise = out_r && !out_prev_r;

    // Three-stage synchroniser. Only the second stage reads the first, since
    // the first may still be resolving when it is sampled.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync_r <= 3'h0;
        end else begin
            sync_r <= {sync_r[1:0], cmp_raw_i};
        end
    end

    // Polarity is applied after the synchroniser, so a change of polarity
    // moves the result without waiting for the pin and may raise pending.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_r <= 1'b0;
        end else if (sync_agree) begin
            out_r <= sync_r[2] ^ control_o[`CTRL_POL_BIT];
        end
    end

    // Resetting to 0 matches the idle result, so no false edge follows reset.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_prev_r <= 1'b0;
        end else begin
            out_prev_r <= out_r;
        end
    end

    // Only bit 0 is stored; reserved bits are not kept and always read as 0.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_permit_bit_r <= 1'b0;
        end else if (wr_en) begin
            irq_permit_bit_r <= req_i.wdata[0];
        end
    end

    // Rising edge of the adjusted result sets pending while the permit bit is 1; set wins over a same-cycle clear.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_pending_bit_r <= 1'b0;
        end else if (irq_permit_bit_r && out_rise) begin
            irq_pending_bit_r <= 1'b1;
        end else if (wr_st && !req_i.wdata[0]) begin
            irq_pending_bit_r <= 1'b0;
        end
    end

    // Any first write to the lock register spends the single chance, even a
    // write of 0, so software that means to lock must write 1 the first time.
    // Only a reset gives the chance back.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            write_once_freeze_bit_r <= 1'b0;
            lock_used_r <= 1'b0;
        end else if (wr_lk && !lock_used_r) begin
            write_once_freeze_bit_r <= req_i.wdata[0];
            lock_used_r <= 1'b1;
        end
    end

    // Control keeps the live output in its read-only bit regardless of the lock.
    // Reserved bits are masked on write so that they always read back as 0.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            control_o <= `REG_RESET;
        end else begin
            control_o[`CTRL_OUT_BIT] <= out_r;
            if (wr_ctrl) begin
                control_o[15:0] <= req_i.wdata[15:0] & `CTRL_WR_MASK;
            end
        end
    end

    // Filter configuration; the filter itself lives beside the analog core.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            filter_config_o <= `REG_RESET;
        end else if (wr_filc) begin
            filter_config_o <= req_i.wdata & `FILC_WR_MASK;
        end
    end

    // Filter clock divider; reserved upper bits are dropped by the mask.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            filter_prescaler_o <= `REG_RESET;
        end else if (wr_filp) begin
            filter_prescaler_o <= req_i.wdata & `FILP_WR_MASK;
        end
    end

    // The request line is registered so that it comes straight from a flop;
    // it therefore trails the pending bit by one cycle. Clearing the permit
    // bit drops the line without losing the pending event.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_pending_bit_r && irq_permit_bit_r;
        end
    end

    // Read multiplexer. Unmapped offsets, including the reserved hole between
    // status and lock, read as 0. Locked registers still read normally.
    always_comb begin
        rdata_nxt = `REG_RESET;
        case (req_i.addr)
            `OFS_IRQ_ENABLE: rdata_nxt = one_bit_word(irq_permit_bit_r);
            `OFS_IRQ_STATUS: rdata_nxt = one_bit_word(irq_pending_bit_r);
            `OFS_CONFIG_LOCK: rdata_nxt = one_bit_word(write_once_freeze_bit_r);
            `OFS_CMP_CONTROL: rdata_nxt = control_o;
            `OFS_FILTER_CONFIG: rdata_nxt = filter_config_o;
            `OFS_FILTER_PRESCALER: rdata_nxt = filter_prescaler_o;
            default: rdata_nxt = `REG_RESET;
        endcase
    end

    // Read data loads only on a read strobe and holds between reads, so a
    // slow master may sample it any time before its next read.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o <= `REG_RESET;
        end else if (req_i.rd) begin
            rdata_o <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// [test/cmp_chk_checker.sv]
// Port assertions for the comparator bank.
// Bound onto the bank below.
`timescale 1ns/10ps
`default_nettype none
module cmp_chk (
    input wire logic sys_clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire cmp_ctrl_pkg::reg_req_s req_i, // Request.
    input wire logic cmp_raw_i, // Raw level.
    input wire logic [31:0] rdata_o, // Read data.
    input wire logic [31:0] control_o, // Control.
    input wire logic [31:0] filter_config_o, // Filter.
    input wire logic [31:0] filter_prescaler_o, // Prescaler.
    input wire logic irq_o // Request line.
);
    logic en_r, lk_r, used_r;
    wire logic w = req_i.wr;
    wire logic [4:0] a = req_i.addr;
    wire logic d = req_i.wdata[0];
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) {en_r, lk_r, used_r} <= 3'h0;
        else if (w && a == 5'h00) en_r <= d;
        else if (w && a == 5'h0C && !used_r) {lk_r, used_r} <= {d, 1'b1};
    end
    perm_off_a: assert property (w && a == 5'h00 && !d |-> ##2 !irq_o) else $error("on");
    gate_irq_a: assert property (irq_o |-> $past(en_r)) else $error("gate");
    pend_clr_a: assert property (w && a == 5'h04 && !d && $stable(control_o[17]) ##1
        $stable(control_o[17]) |=> !irq_o) else $error("clear");
    lock_rd_a: assert property (req_i.rd && a == 5'h0C |=> rdata_o[0] == $past(lk_r))
        else $error("lock");
    lock_wr_a: assert property (lk_r && w && a == 5'h14 |=> $stable(filter_config_o))
        else $error("frozen");
    open_wr_a: assert property (!lk_r && w && a == 5'h18 |=>
        filter_prescaler_o[15:0] == $past(req_i.wdata[15:0])) else $error("open");
    set_irq_a: assert property ($rose(control_o[17]) && $past(en_r) && en_r ##1
        (en_r && !w)[*3]
        |-> irq_o) else $error("set");
    cover property ($rose(irq_o));
    cover property (lk_r && w && a == 5'h14);
    cover property (w && a == 5'h04);
endmodule
bind comparator_ctrl_regs cmp_chk u_cmp_chk (.sys_clk_i, .rst_i, .req_i, .cmp_raw_i, .rdata_o,
    .control_o, .filter_config_o, .filter_prescaler_o, .irq_o);
`default_nettype wire

// [test/cmp_core_model.sv]
// Stand-in for the analog comparator core.
// Its result is the commanded level sampled at falling edges, delayed by lag_i further falling edges.
`timescale 1ns/10ps
`default_nettype none
module cmp_core_model (
    input wire logic sys_clk_i, // Clock.
    input wire logic level_i, // Level.
    input wire logic [2:0] lag_i, // Delay.
    output logic cmp_o // Result.
);
    logic [7:0] dly_r = 8'h00;
    always @(negedge sys_clk_i) dly_r <= {dly_r[6:0], level_i};
    assign cmp_o = dly_r[lag_i];
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the comparator bank.
// Requests change on falling edges; the core model feeds the raw level.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cmp_ctrl_pkg::*;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, lvl = 1'b0, cmp_raw_i, irq_o;
    logic [2:0] lag = 3'h0;
    reg_req_s req_i = '0;
    logic [31:0] rdata_o, control_o, filter_config_o, filter_prescaler_o;
    int errors = 0, compares = 0, cyc = 0;
    comparator_ctrl_regs u_comparator_ctrl_regs (.sys_clk_i, .rst_i, .req_i, .cmp_raw_i,
        .rdata_o, .control_o, .filter_config_o, .filter_prescaler_o, .irq_o);
    cmp_core_model u_cmp_core_model (.sys_clk_i, .level_i(lvl), .lag_i(lag), .cmp_o(cmp_raw_i));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (++cyc == 3000) begin errors++; summarize(); end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin errors++; $display("Error %0t got %h exp %h", $time, got, exp); end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(negedge sys_clk_i) req_i = '{1'b1, 1'b0, a, d};
        @(negedge sys_clk_i) req_i = '0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(negedge sys_clk_i) req_i = '{1'b0, 1'b1, a, 32'h0};
        @(negedge sys_clk_i) req_i = '0;
        chk(rdata_o, e);
    endtask
    // Waits boundedly for the request line (c=0) or the result bit (c=1).
    task automatic wt(input bit c, input logic e);
        for (int i = 0; i < 20 && (c ? control_o[17] : irq_o) !== e; i++) @(negedge sys_clk_i);
        chk({31'h0, c ? control_o[17] : irq_o}, {31'h0, e});
    endtask
    task automatic t_reset();
        logic [4:0] ofs [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};
        foreach (ofs[i]) rd(ofs[i], 32'h0);
    endtask
    task automatic t_irq();
        wr(5'h14, 32'h00000107);
        wr(5'h00, 32'h00000001);
        lvl = 1'b1;
        wt(0, 1'b1);
        rd(5'h04, 32'h1);
        lvl = 1'b0;
        wr(5'h04, 32'h0);
        wt(0, 1'b0);
        wr(5'h00, 32'h0);
        lag = 3'h7;
        wr(5'h10, 32'h00000800);
        wt(1, 1'b1);
        rd(5'h04, 32'h0);
        wr(5'h00, 32'h1);
        lvl = 1'b1;
        wt(1, 1'b0);
        lvl = 1'b0;
        wt(0, 1'b1);
        wr(5'h00, 32'h0);
        wt(0, 1'b0);
        rd(5'h04, 32'h1);
    endtask
    task automatic t_lock();
        wr(5'h18, 32'h0000ABCD);
        rd(5'h18, 32'h0000ABCD);
        wr(5'h0C, 32'h1);
        wr(5'h0C, 32'h0);
        rd(5'h0C, 32'h1);
        wr(5'h18, 32'h00001234);
        wr(5'h14, 32'h0);
        wr(5'h10, 32'h0);
        rd(5'h18, 32'h0000ABCD);
        chk(filter_config_o, 32'h00000107);
        chk(control_o, 32'h00020800);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rst_i = 1'b0;
        t_reset();
        t_irq();
        t_lock();
        summarize();
    end
    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
endmodule
`default_nettype wire
